// file: hw/scan_interval_timing.sv
// Purpose: computes the fast-mode minimum scan interval and paces scans
// Assumes: configuration arrives from the command parser on the same clock
// Notes:   interval is produced in clock cycles; programmed intervals in 100 ms units
//
// Function
// R1: group interval is ceil(groups/4) times period
// R2: 60 Hz group period is 16.67 ms
// R3: 50 Hz group period is 20.00 ms
// R4: any configured channel marks group occupied
// R5: sample interval is channels*(weight+12)*period
// R6: 60 Hz sample period is 0.52083 ms
// R7: 50 Hz sample period is 0.62500 ms
// R8: weight defaults to 32 samples per channel
// R9: sample interval uses channel count only
// R10: all-zero programmed interval selects fast mode
// R11: extremes, alarms, level refreshed every minimum interval
// R12: line frequency sampled on configuration change
`default_nettype none
module scan_interval_timing #(
    parameter int unsigned CHANNELS       = 992,
    parameter int unsigned TENTH_CYCLES   = 10000000,  // cycles in 100 ms
    parameter int unsigned GROUP_60_CYC   = scan_timing_pkg::GROUP_PERIOD_60HZ_CYC,
    parameter int unsigned GROUP_50_CYC   = scan_timing_pkg::GROUP_PERIOD_50HZ_CYC,
    parameter int unsigned SAMPLE_60_CYC  = scan_timing_pkg::SAMPLE_PERIOD_60HZ_CYC,
    parameter int unsigned SAMPLE_50_CYC  = scan_timing_pkg::SAMPLE_PERIOD_50HZ_CYC
) (
    input  wire logic                    sys_clk_in,      // system clock
    input  wire logic                    reset_n_in,      // synchronous, active low
    input  wire logic [CHANNELS-1:0]     chan_map_in,     // one bit per configured channel
    input  wire logic                    cfg_load_in,     // pulse: configuration changed
    input  wire scan_timing_pkg::scan_cfg_t cfg_in,       // line, variant, weight
    input  wire logic                    weight_load_in,  // pulse: host sets weight
    input  wire scan_timing_pkg::scan_ivl_t ivl_in,       // programmed intervals
    input  wire logic                    acq_phase_in,    // 1: acquisition interval applies
    output logic [47:0]                  min_interval_out,// minimum interval, cycles
    output logic                         interval_valid_out, // interval computed
    output logic                         refresh_tick_out,// pulse each minimum interval
    output logic                         scan_tick_out    // pulse each scan start
);
    localparam int unsigned CW = $clog2(CHANNELS+1);

    // elaboration checks: counts above ten bits or zero periods cannot be served
    if (CHANNELS > 1023) begin : g_bad_channels
        $error("channel count too large");
    end
    if (TENTH_CYCLES == 0 || GROUP_60_CYC == 0 || GROUP_50_CYC == 0 ||
        SAMPLE_60_CYC == 0 || SAMPLE_50_CYC == 0) begin : g_bad_period
        $error("zero period");
    end

    // =====================================================================
    // configuration capture
    // =====================================================================
    logic        line_50hz;   // captured line selection
    logic        sample_mode; // captured variant selection
    logic [7:0]  weight;      // samples per channel
    logic        start_count; // kicks the group counter

    // line and variant latch only when the channel setup changes
    // start is delayed one cycle so the map and selections are settled
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            line_50hz   <= 1'b0;
            sample_mode <= 1'b0;
            start_count <= 1'b0;
        end else begin
            start_count <= cfg_load_in;
            if (cfg_load_in) begin
                line_50hz   <= cfg_in.line_50hz; // R12
                sample_mode <= cfg_in.sample_mode;
            end
        end
    end

    // weight held at its default until the host programs another
    // a new weight applies from the next channel count onward
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            weight <= scan_timing_pkg::WEIGHT_RESET; // R8
        end else if (weight_load_in) begin
            weight <= cfg_in.weight;
        end
    end

    // =====================================================================
    // group and channel counting
    // =====================================================================
    logic          count_done;  // counter finished
    logic [CW-1:0] group_count; // occupied_group_count
    logic [CW-1:0] chan_count;  // configured_channel_count

    group_counter #(.CHANNELS(CHANNELS)) u_count (
        .sys_clk_in      (sys_clk_in),
        .reset_n_in      (reset_n_in),
        .start_in        (start_count),
        .chan_map_in     (chan_map_in),
        .done_out        (count_done),
        .group_count_out (group_count),
        .chan_count_out  (chan_count)
    );

    // =====================================================================
    // interval computation
    // =====================================================================
    scan_timing_pkg::calc_state_t state; // computation state
    logic [23:0] units;   // multiplier: units or samples
    logic [47:0] product; // computed interval in cycles
    logic [31:0] period;  // selected period in cycles
    logic        drop_valid; // valid about to fall for a new computation

    // period picks between line frequencies for the active variant
    // uses the latched line choice, never the live input
    always_comb begin
        if (sample_mode)
            period = line_50hz ? 32'(SAMPLE_50_CYC) : 32'(SAMPLE_60_CYC); // R6 R7
        else
            period = line_50hz ? 32'(GROUP_50_CYC) : 32'(GROUP_60_CYC);   // R2 R3
    end

    // sequence: wait for counts, form multiplier, multiply
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            state              <= scan_timing_pkg::CALC_IDLE;
            units              <= '0;
            product            <= '0;
            min_interval_out   <= '0;
            interval_valid_out <= 1'b0;
        end else begin
            case (state)
                scan_timing_pkg::CALC_IDLE: begin
                    // a load while busy starts nothing but still latches line and variant; the host waits for valid
                    if (start_count) begin
                        interval_valid_out <= 1'b0;
                        state              <= scan_timing_pkg::CALC_COUNT;
                    end
                end
                scan_timing_pkg::CALC_COUNT: begin
                    if (count_done) begin
                        if (sample_mode)
                            // count only, placement ignored
                            units <= 24'(chan_count) * (24'(weight) +
                                     24'(scan_timing_pkg::SAMPLE_OVERHEAD)); // R5 R9
                        else
                            // ceiling of groups over four
                            units <= 24'((group_count +
                                     CW'(scan_timing_pkg::GROUPS_PER_UNIT - 1)) /
                                     CW'(scan_timing_pkg::GROUPS_PER_UNIT)); // R1
                        state <= scan_timing_pkg::CALC_MUL;
                    end
                end
                scan_timing_pkg::CALC_MUL: begin
                    // a cycle of its own keeps the wide product off the count path
                    product <= 48'(units) * 48'(period); // R1 R5
                    state   <= scan_timing_pkg::CALC_DONE;
                end
                scan_timing_pkg::CALC_DONE: begin
                    // a zero product leaves valid low, holding both tick counters idle
                    min_interval_out   <= product;
                    interval_valid_out <= (product != '0);
                    state              <= scan_timing_pkg::CALC_IDLE;
                end
                default: state <= scan_timing_pkg::CALC_IDLE;
            endcase
        end
    end

    // =====================================================================
    // minimum interval pacing
    // =====================================================================
    logic [47:0] min_cnt;  // cycles into current minimum interval
    logic        min_wrap; // minimum interval elapsed

    // wrap one cycle early so the registered tick lands on the boundary
    assign min_wrap = interval_valid_out && (min_cnt >= min_interval_out - 48'h1);

    // ticks stop as a recomputation starts, so no tick outlives valid
    assign drop_valid = start_count && (state == scan_timing_pkg::CALC_IDLE);

    // refresh tick for extremes, alarms and level event
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in || !interval_valid_out || drop_valid) begin
            min_cnt          <= '0;
            refresh_tick_out <= 1'b0;
        end else begin
            refresh_tick_out <= min_wrap; // R11
            min_cnt          <= min_wrap ? 48'h0 : min_cnt + 48'h1;
        end
    end

    // =====================================================================
    // programmed scan pacing
    // =====================================================================
    logic [21:0] prog_ivl;  // active programmed interval, 100 ms units
    logic [47:0] prog_cyc;  // programmed interval in cycles
    logic [47:0] scan_cnt;  // cycles since last scan
    logic        fast;      // fast mode active
    logic [47:0] target;    // effective scan period

    always_comb begin
        prog_ivl = acq_phase_in ? ivl_in.acquisition : ivl_in.normal;
        prog_cyc = 48'(prog_ivl) * 48'(TENTH_CYCLES);
        fast     = (prog_ivl == '0); // R10
        // a programmed interval never beats the minimum
        target   = (fast || prog_cyc < min_interval_out) ? min_interval_out : prog_cyc; // R10
    end

    // scan tick at the effective period
    // a shortened target fires at once, then runs at the new period
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in || !interval_valid_out || drop_valid) begin
            scan_cnt      <= '0;
            scan_tick_out <= 1'b0;
        end else if (scan_cnt >= target - 48'h1) begin
            scan_cnt      <= '0;
            scan_tick_out <= 1'b1;
        end else begin
            scan_cnt      <= scan_cnt + 48'h1;
            scan_tick_out <= 1'b0;
        end
    end
endmodule // scan_interval_timing
`default_nettype wire

// file: hw/scan_timing_pkg.sv
// Purpose: shared constants and carrier types for the scan interval timing block
// Assumes: 100 MHz system clock
// Notes:   periods are held in nanoseconds, cycle counts derived from the clock rate
`default_nettype none
package scan_timing_pkg;
    // =====================================================================
    // clock and timing
    // =====================================================================
    localparam int unsigned CLK_PERIOD_NS       = 10;        // 100 MHz system clock
    localparam int unsigned GROUP_PERIOD_60HZ_NS = 16670000; // 16.67 ms per group unit
    localparam int unsigned GROUP_PERIOD_50HZ_NS = 20000000; // 20.00 ms per group unit
    localparam int unsigned SAMPLE_PERIOD_60HZ_NS = 520830;  // 0.52083 ms per sample
    localparam int unsigned SAMPLE_PERIOD_50HZ_NS = 625000;  // 0.62500 ms per sample
    localparam int unsigned GROUP_PERIOD_60HZ_CYC  = GROUP_PERIOD_60HZ_NS / CLK_PERIOD_NS;
    localparam int unsigned GROUP_PERIOD_50HZ_CYC  = GROUP_PERIOD_50HZ_NS / CLK_PERIOD_NS;
    localparam int unsigned SAMPLE_PERIOD_60HZ_CYC = SAMPLE_PERIOD_60HZ_NS / CLK_PERIOD_NS;
    localparam int unsigned SAMPLE_PERIOD_50HZ_CYC = SAMPLE_PERIOD_50HZ_NS / CLK_PERIOD_NS;

    // =====================================================================
    // computation constants and reset values
    // =====================================================================
    localparam int unsigned GROUP_SIZE        = 4;   // channels per aligned group
    localparam int unsigned GROUPS_PER_UNIT   = 4;   // groups per sixteen-channel unit
    localparam int unsigned SAMPLE_OVERHEAD   = 12;  // fixed samples added per channel
    localparam logic [7:0]  WEIGHT_RESET      = 8'h20; // default 32 samples per channel

    // =====================================================================
    // types
    // =====================================================================
    typedef enum logic [1:0] {
        CALC_IDLE  = 2'b00,
        CALC_COUNT = 2'b01,
        CALC_MUL   = 2'b11,
        CALC_DONE  = 2'b10
    } calc_state_t;

    // configuration as delivered by the command parser
    typedef struct packed {
        logic        line_50hz;    // 1: 50 Hz mains, 0: 60 Hz mains
        logic        sample_mode;  // 1: sample-based variant, 0: group-based
        logic [7:0]  weight;       // samples per channel
    } scan_cfg_t;

    // programmed intervals, in units of 100 ms; zero selects fast mode
    typedef struct packed {
        logic [21:0] normal;
        logic [21:0] acquisition;
    } scan_ivl_t;
endpackage
`default_nettype wire

// file: hw/group_counter.sv
// Purpose: counts occupied aligned channel groups and configured channels
// Assumes: channel map is stable while the walk is busy, from start until done
// Notes:   one group per clock, result valid with done pulse
`default_nettype none
module group_counter #(
    parameter int unsigned CHANNELS = 992
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  reset_n_in,
    input  wire logic                  start_in,
    input  wire logic [CHANNELS-1:0]   chan_map_in,
    output logic                       done_out,
    output logic [$clog2(CHANNELS+1)-1:0] group_count_out,
    output logic [$clog2(CHANNELS+1)-1:0] chan_count_out
);
    localparam int unsigned GROUPS = CHANNELS / scan_timing_pkg::GROUP_SIZE;
    localparam int unsigned CW     = $clog2(CHANNELS+1);
    localparam int unsigned IW     = $clog2(GROUPS+1);

    initial begin
        if (CHANNELS % scan_timing_pkg::GROUP_SIZE != 0) $error("channels not multiple of 4");
    end

    logic          busy;   // walking the groups
    logic [IW-1:0] idx;    // current group index
    logic [scan_timing_pkg::GROUP_SIZE-1:0] grp; // bits of current group
    logic [2:0]    ones;   // configured channels in current group

    // =====================================================================
    // group slice and popcount
    // =====================================================================
    always_comb begin
        grp  = chan_map_in[idx*scan_timing_pkg::GROUP_SIZE +: scan_timing_pkg::GROUP_SIZE];
        ones = 3'(grp[0]) + 3'(grp[1]) + 3'(grp[2]) + 3'(grp[3]);
    end

    // =====================================================================
    // walk, one group per cycle
    // =====================================================================
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            busy            <= 1'b0;
            idx             <= '0;
            done_out        <= 1'b0;
            group_count_out <= '0;
            chan_count_out  <= '0;
        end else begin
            done_out <= 1'b0;
            if (start_in && !busy) begin
                busy            <= 1'b1;
                idx             <= '0;
                group_count_out <= '0;
                chan_count_out  <= '0;
            end else if (busy) begin
                // any configured channel marks the group occupied
                if (|grp) group_count_out <= group_count_out + CW'(1); // R4
                chan_count_out <= chan_count_out + CW'(ones);          // R9
                if (idx == IW'(GROUPS-1)) begin
                    busy     <= 1'b0;
                    done_out <= 1'b1;
                end else begin
                    idx <= idx + IW'(1);
                end
            end
        end
    end
endmodule // group_counter
`default_nettype wire

// file: test/scan_host_model.sv
// Purpose: host side model issuing channel, weight and interval settings
// Assumes: settings change at the falling clock edge
// Notes:   channel map is held until the next load
`default_nettype none
module scan_host_model #(
    parameter int unsigned CHANNELS = 32
) (
    input  wire logic                       sys_clk_in,
    output var  logic [CHANNELS-1:0]        chan_map_out,
    output var  logic                       cfg_load_out,
    output var  scan_timing_pkg::scan_cfg_t cfg_out,
    output var  logic                       weight_load_out,
    output var  scan_timing_pkg::scan_ivl_t ivl_out,
    output var  logic                       acq_phase_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================================
    // host commands
    // =====================================================================
    // idle levels at time zero
    initial begin
        chan_map_out = '0;
        cfg_load_out = 1'b0;
        cfg_out = '0;
        weight_load_out = 1'b0;
        ivl_out = '0;
        acq_phase_out = 1'b0;
    end
    // one-cycle configuration pulse; map held for the count afterwards
    task automatic load(input logic [CHANNELS-1:0] map, input logic line, input logic mode);
        @(negedge sys_clk_in);
        chan_map_out = map;
        cfg_out.line_50hz = line;
        cfg_out.sample_mode = mode;
        cfg_load_out = 1'b1;
        @(negedge sys_clk_in);
        cfg_load_out = 1'b0;
    endtask
    // weight goes in before the configuration that uses it
    task automatic set_weight(input logic [7:0] w);
        @(negedge sys_clk_in);
        cfg_out.weight = w;
        weight_load_out = 1'b1;
        @(negedge sys_clk_in);
        weight_load_out = 1'b0;
    endtask
    // programmed intervals; zero asks for fast mode
    task automatic set_ivl(input logic [21:0] nrm, input logic [21:0] acq, input logic ph);
        @(negedge sys_clk_in);
        ivl_out.normal = nrm;
        ivl_out.acquisition = acq;
        acq_phase_out = ph;
    endtask
endmodule // scan_host_model
`default_nettype wire

// file: test/scan_interval_timing_assertions.sv
// Purpose: port-level checks of the scan interval timing block
// Assumes: one clock, synchronous active-low reset
// Notes:   gap counters track tick spacing against the computed interval
`default_nettype none
module scan_interval_timing_checker #(
    parameter int unsigned CHANNELS     = 992,
    parameter int unsigned TENTH_CYCLES = 10000000
) (
    input wire logic                       sys_clk_in,
    input wire logic                       reset_n_in,
    input wire logic                       cfg_load_in,
    input wire scan_timing_pkg::scan_ivl_t ivl_in,
    input wire logic                       acq_phase_in,
    input wire logic [47:0]                min_interval_out,
    input wire logic                       interval_valid_out,
    input wire logic                       refresh_tick_out,
    input wire logic                       scan_tick_out
);
    // =====================================================================
    // helper logic
    // =====================================================================
    localparam int LAT = CHANNELS / 4 + 5;   // load to valid latency
    logic [21:0] prog, prog_q;               // selected programmed interval
    logic [47:0] prog_cyc, exp_scan;         // expected scan spacing
    logic [47:0] rgap, sgap;                 // cycles since last tick
    logic        sseen;                      // scan gap known
    assign prog = acq_phase_in ? ivl_in.acquisition : ivl_in.normal;
    assign prog_cyc = 48'(prog) * 48'(TENTH_CYCLES);
    assign exp_scan = (prog_cyc > min_interval_out) ? prog_cyc : min_interval_out;
    // refresh spacing, restarted whenever the interval is not valid
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in || !interval_valid_out) begin
            rgap <= '0;
        end else if (refresh_tick_out) begin
            rgap <= 48'h1;
        end else rgap <= rgap + 48'h1;
    end
    // scan spacing, forgotten when the programmed interval moves
    always_ff @(posedge sys_clk_in) begin
        prog_q <= prog;
        if (!reset_n_in || !interval_valid_out || prog != prog_q) begin
            sgap <= '0;
            sseen <= 1'b0;
        end else if (scan_tick_out) begin
            sgap <= 48'h1;
            sseen <= 1'b1;
        end else sgap <= sgap + 48'h1;
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    // =====================================================================
    // assertions
    // =====================================================================
    sequence reload_s;
        cfg_load_in ##1 1'b1;
    endsequence
    valid_latency_a: assert property ($rose(interval_valid_out) |-> $past(cfg_load_in, LAT))
        else $error("interval valid at wrong latency");
    reload_drop_a: assert property (reload_s |=> !interval_valid_out)
        else $error("valid kept across reconfiguration");
    nonzero_result_a: assert property (interval_valid_out |-> min_interval_out != '0)
        else $error("valid with zero interval");
    hold_interval_a: assert property (interval_valid_out && $past(interval_valid_out)
        |-> $stable(min_interval_out)) else $error("interval moved while valid");
    tick_valid_a: assert property ((refresh_tick_out || scan_tick_out) |-> interval_valid_out)
        else $error("tick without interval");
    refresh_pulse_a: assert property (refresh_tick_out |=> !refresh_tick_out)
        else $error("refresh tick longer than a cycle");
    scan_pulse_a: assert property (scan_tick_out |=> !scan_tick_out)
        else $error("scan tick longer than a cycle");
    refresh_period_a: assert property (refresh_tick_out |-> rgap == min_interval_out)
        else $error("refresh spacing wrong");
    scan_period_a: assert property (scan_tick_out && sseen |-> sgap == exp_scan)
        else $error("scan spacing wrong");
endmodule // scan_interval_timing_checker
bind scan_interval_timing scan_interval_timing_checker #(
    .CHANNELS(CHANNELS), .TENTH_CYCLES(TENTH_CYCLES)) timing_chk (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .cfg_load_in(cfg_load_in),
    .ivl_in(ivl_in), .acq_phase_in(acq_phase_in), .min_interval_out(min_interval_out),
    .interval_valid_out(interval_valid_out), .refresh_tick_out(refresh_tick_out),
    .scan_tick_out(scan_tick_out));
`default_nettype wire

// file: test/scan_interval_timing_test.sv
// Purpose: self-checking bench for the scan interval timing block
// Assumes: shortened periods, 32 channels
// Notes:   expectations come from the interval formulas below
`default_nettype none
module scan_interval_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================================
    // clock, reset, instances
    // =====================================================================
    localparam int G60 = 7, G50 = 9, S60 = 3, S50 = 2;  // shortened periods
    logic                       clk = 1'b0;     // 100 MHz
    logic                       reset_n = 1'b0; // synchronous reset
    logic [31:0]                map;            // channel map
    logic                       load, wload, acq;
    scan_timing_pkg::scan_cfg_t cfg;
    scan_timing_pkg::scan_ivl_t ivl;
    logic [47:0]                min_ivl;
    logic                       valid, refresh, scan;
    int                         n_mismatch = 0, compares = 0;
    always #5 clk = ~clk;
    scan_host_model #(.CHANNELS(32)) host (.sys_clk_in(clk), .chan_map_out(map),
        .cfg_load_out(load), .cfg_out(cfg), .weight_load_out(wload), .ivl_out(ivl),
        .acq_phase_out(acq));
    scan_interval_timing #(.CHANNELS(32), .TENTH_CYCLES(10), .GROUP_60_CYC(G60),
        .GROUP_50_CYC(G50), .SAMPLE_60_CYC(S60), .SAMPLE_50_CYC(S50)) DUT (
        .sys_clk_in(clk), .reset_n_in(reset_n), .chan_map_in(map), .cfg_load_in(load),
        .cfg_in(cfg), .weight_load_in(wload), .ivl_in(ivl), .acq_phase_in(acq),
        .min_interval_out(min_ivl), .interval_valid_out(valid),
        .refresh_tick_out(refresh), .scan_tick_out(scan));
    // =====================================================================
    // shared tasks
    // =====================================================================
    task automatic test_done;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        compares++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
            n_mismatch++;
        end
    endtask
    // load a configuration, wait for the result and compare it with the formula
    task automatic run_cfg(input logic [31:0] m, input bit line, input bit mode, input int w);
        int g, c, n;
        logic [47:0] exp;
        g = 0;
        c = 0;
        n = 0;
        for (int i = 0; i < 32; i++) c += m[i];
        for (int i = 0; i < 8; i++) g += |m[4*i +: 4];
        exp = mode ? 48'(c * (w + 12) * (line ? S50 : S60)) : 48'((g + 3) / 4 * (line ? G50 : G60));
        host.load(m, line, mode);
        repeat (3) @(negedge clk);
        while (valid !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        if (valid !== 1'b1) begin
            $display("[FAIL] interval_valid_out expected 1 seen %b", valid);
            n_mismatch++;
            test_done();
        end
        check("min_interval_out", exp, min_ivl);
    endtask
    // spacing between the second and third tick seen
    task automatic tick_gap(input bit sel, input int exp);
        int n, k, last;
        n = 0;
        k = 0;
        last = 0;
        while (k < 3 && n < 400) begin
            @(negedge clk);
            n++;
            if ((sel ? scan : refresh) === 1'b1) begin
                k++;
                if (k == 2) last = n;
            end
        end
        if (k < 3) begin
            $display("[FAIL] tick count expected 3 seen %0d", k);
            n_mismatch++;
            test_done();
        end
        check(sel ? "scan gap" : "refresh gap", 48'(exp), 48'(n - last));
    endtask
    // =====================================================================
    // scenarios
    // =====================================================================
    task automatic group_scan;
        run_cfg(32'h1010_405f, 1'b0, 1'b0, 32);
        run_cfg(32'h8888_8888, 1'b0, 1'b0, 32);
        run_cfg(32'h0000_00ff, 1'b1, 1'b0, 32);
        run_cfg(32'h0000_ffff, 1'b1, 1'b0, 32);
    endtask
    task automatic sample_scan;
        run_cfg(32'h8888_8888, 1'b0, 1'b1, 32);
        run_cfg(32'h0000_00ff, 1'b0, 1'b1, 32);
        host.set_weight(8'h01);
        run_cfg(32'h0000_00ff, 1'b1, 1'b1, 1);
    endtask
    task automatic fast_mode;
        host.set_ivl(22'h0, 22'h3, 1'b0);
        run_cfg(32'hffff_ffff, 1'b0, 1'b0, 1);
        tick_gap(1'b0, 2 * G60);
        tick_gap(1'b1, 2 * G60);
        host.set_ivl(22'h0, 22'h3, 1'b1);
        tick_gap(1'b1, 30);
        host.set_ivl(22'h0, 22'h1, 1'b1);
        tick_gap(1'b1, 2 * G60);
        host.set_ivl(22'h2, 22'h0, 1'b0);
        tick_gap(1'b1, 20);
        host.set_ivl(22'h2, 22'h0, 1'b1);
        tick_gap(1'b1, 2 * G60);
        tick_gap(1'b0, 2 * G60);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        group_scan();
        sample_scan();
        fast_mode();
        test_done();
    end
endmodule // scan_interval_timing_test
`default_nettype wire
